// >>> hdl/dct_pkg.sv
// Shared constants, types and helpers for the counter/timer block
package dct_pkg;

   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int BYTE_W = 8;

   // Register index (byte address / 4)
   localparam logic [3:0] REG_AUX    = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_PRE_HI = 4'h6;
   localparam logic [3:0] REG_PRE_LO = 4'h7;
   localparam logic [3:0] REG_MASK   = 4'h8;
   localparam logic [3:0] REG_PINCFG = 4'hD;
   localparam logic [3:0] CMD_START  = 4'hE;
   localparam logic [3:0] CMD_STOP   = 4'hF;

   // Field positions
   localparam int AUX_MODE_LSB  = 4;
   localparam int PIN_SEL_LSB   = 2;
   localparam int PIN_LVL_BIT   = 7;
   localparam int READY_BIT     = 3;

   localparam logic [CNT_W-1:0] PRELOAD_RST = 16'h0002;
   localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
   localparam int               PRESCALE    = 16;

   typedef enum logic [2:0] {
      MODE_CNT_IP2   = 3'h0,
      MODE_CNT_TXA   = 3'h1,
      MODE_CNT_TXB   = 3'h2,
      MODE_CNT_XT16  = 3'h3,
      MODE_TMR_IP2   = 3'h4,
      MODE_TMR_IP216 = 3'h5,
      MODE_TMR_XTAL  = 3'h6,
      MODE_TMR_XT16  = 3'h7
   } dct_mode_e;

   localparam dct_mode_e MODE_RST = MODE_TMR_XTAL;

   typedef enum logic [1:0] {
      PIN_OUTPORT = 2'h0,
      PIN_CT      = 2'h1,
      PIN_TXB     = 2'h2,
      PIN_RXB     = 2'h3
   } dct_pinsel_e;

   // Gray codes along idle -> ack
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } dct_bus_e;

   // Gray codes: stopped -> counting, timer next to counting
   typedef enum logic [1:0] {
      CT_STOP  = 2'b00,
      CT_COUNT = 2'b01,
      CT_TIMER = 2'b11
   } dct_ct_e;

   typedef struct packed {
      dct_mode_e   mode;
      dct_pinsel_e pin_sel;
      logic        pin_level;
      logic        ready_mask;
   } dct_cfg_s;

   // One-cycle rising-edge ticks of the source inputs
   typedef struct packed {
      logic ip2;
      logic txa;
      logic txb;
      logic xtal;
   } dct_src_s;

   function automatic logic is_timer(input dct_mode_e m);
      return m[2];
   endfunction : is_timer

   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction : reg_index

endpackage : dct_pkg

// >>> hdl/dct_sync.sv
// Two-flop synchronisers with rising-edge pulse for source inputs
`timescale 1ns/1ps
module dct_sync
   import dct_pkg::*;
#(
   parameter int W = 4
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] rise
);

   logic [W-1:0] meta;
   logic [W-1:0] sync;
   logic [W-1:0] last;

   if (W < 1)
   begin : g_chk
      $error("dct_sync: W must be at least 1");
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta <= '0;
         sync <= '0;
         last <= '0;
      end
      else
      begin
         meta <= async_in;
         sync <= meta;
         last <= sync;
      end
   end

   assign rise = sync & ~last;

endmodule : dct_sync

// >>> hdl/dct_prescale.sv
// Divide a tick stream by a fixed ratio
`timescale 1ns/1ps
module dct_prescale
   import dct_pkg::*;
#(
   parameter int DIV = PRESCALE
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic tick_in,
   output logic      tick_out
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt;

   if (DIV < 2)
   begin : g_chk
      $error("dct_prescale: DIV must be at least 2");
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cnt <= '0;
      else if (tick_in)
         cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
   end

   assign tick_out = tick_in && (cnt == LAST);

endmodule : dct_prescale

// >>> hdl/dct_top.sv
// Counter/timer with Avalon-MM register slave
// Contract
// RULE1 - Preload held in two write-only byte registers
// RULE2 - Host never loads preload below 0002
// RULE3 - Timer square wave period is twice preload
// RULE4 - Preload change applies from next half-period
// RULE5 - Timer runs freely; start read restarts cycle
// RULE6 - Timer sets ready once per square cycle
// RULE7 - Stop read clears ready; timer keeps running
// RULE8 - Pin three carries square wave when selected
// RULE9 - After reset timer mode runs, unstoppable
// RULE10 - Host sets pin select 00 at init
// RULE11 - Counter counts down from preload after start
// RULE12 - Counter sets ready on reaching 0000
// RULE13 - Counter wraps past terminal until stopped
// RULE14 - Pin high until terminal; stop restores high
// RULE15 - Counter preload writes apply at next start
// RULE16 - Live count readable as two bytes
// RULE17 - Host stops counter before reading halves
// RULE18 - Codes 000-011 counter with listed sources
// RULE19 - Codes 100-111 timer with listed sources
// RULE20 - Timer ready on every second zero reach
// RULE21 - Interrupt when ready and mask both set
// RULE22 - Timer reloads and toggles at zero; synced
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dct_top
   import dct_pkg::*;
#(
   parameter int PRE_DIV = PRESCALE
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [DATA_W-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              external_input_two,
   input  wire logic              chan_a_tx_1x_clock,
   input  wire logic              chan_b_tx_1x_clock,
   input  wire logic              crystal_clock_input,
   output logic                   output_pin_three_o,
   output logic                   output_pin_three_oe,
   output logic                   interrupt_request_out
);

   if (PRE_DIV < 2)
   begin : g_chk
      $error("dct_top: PRE_DIV must be at least 2");
   end

   dct_bus_e         bus_state;
   dct_ct_e          ct_state;
   dct_cfg_s         cfg;
   dct_src_s         raw_tick;
   logic [BYTE_W-1:0] preload_upper_byte;
   logic [BYTE_W-1:0] preload_lower_byte;
   logic [CNT_W-1:0] preload;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic             ip2_div;
   logic             xtal_div;
   logic             src_tick;
   logic             accept;
   logic             wr_en;
   logic             rd_en;
   logic [3:0]       idx;
   logic             start_cmd;
   logic             stop_cmd;
   logic             aux_wr;
   logic             wave;
   logic             half_odd;
   logic             ct_out;
   logic             ready;
   logic             ready_set;
   logic             at_zero;

   // Source pins come from other clocks: two flops before use
   dct_sync #(
      .W        (4)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in ({external_input_two, chan_a_tx_1x_clock,
                  chan_b_tx_1x_clock, crystal_clock_input}),
      .rise     (raw_tick)
   );  // see RULE22

   dct_prescale #(
      .DIV      (PRE_DIV)
   ) u_pre_ip2 (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .tick_in  (raw_tick.ip2),
      .tick_out (ip2_div)
   );

   dct_prescale #(
      .DIV      (PRE_DIV)
   ) u_pre_xtal (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .tick_in  (raw_tick.xtal),
      .tick_out (xtal_div)
   );

   // Source select per mode code
   always_comb
   begin
      case (cfg.mode)
         MODE_CNT_IP2:   src_tick = raw_tick.ip2;  // see RULE18
         MODE_CNT_TXA:   src_tick = raw_tick.txa;  // see RULE18
         MODE_CNT_TXB:   src_tick = raw_tick.txb;  // see RULE18
         MODE_CNT_XT16:  src_tick = xtal_div;      // see RULE18
         MODE_TMR_IP2:   src_tick = raw_tick.ip2;  // see RULE19
         MODE_TMR_IP216: src_tick = ip2_div;       // see RULE19
         MODE_TMR_XTAL:  src_tick = raw_tick.xtal; // see RULE19
         MODE_TMR_XT16:  src_tick = xtal_div;      // see RULE19
         default:        src_tick = 1'b0;
      endcase
   end

   // Bus slave: every access answers one cycle after it is seen
   assign idx       = reg_index(avs_address);
   assign accept    = (bus_state == BUS_IDLE) && (avs_read || avs_write);
   assign wr_en     = accept && avs_write && avs_byteenable[0];
   assign rd_en     = accept && avs_read;
   assign start_cmd = rd_en && (idx == CMD_START);  // see RULE5
   assign stop_cmd  = rd_en && (idx == CMD_STOP);   // see RULE7
   assign aux_wr    = wr_en && (idx == REG_AUX);
   assign avs_waitrequest = (avs_read || avs_write)
                            && (bus_state != BUS_ACK);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         bus_state <= BUS_IDLE;
      else
      begin
         case (bus_state)
            BUS_IDLE: if (accept) bus_state <= BUS_ACK;
            BUS_ACK:  bus_state <= BUS_IDLE;
            default:  bus_state <= BUS_IDLE;
         endcase
      end
   end

   // Preload bytes have no read path at all
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         preload_upper_byte <= PRELOAD_RST[CNT_W-1:BYTE_W];
         preload_lower_byte <= PRELOAD_RST[BYTE_W-1:0];
      end
      else if (wr_en && (idx == REG_PRE_HI))
         preload_upper_byte <= avs_writedata[BYTE_W-1:0];  // see RULE1
      else if (wr_en && (idx == REG_PRE_LO))
         preload_lower_byte <= avs_writedata[BYTE_W-1:0];  // see RULE1
   end

   assign preload = {preload_upper_byte, preload_lower_byte};

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cfg.mode       <= MODE_RST;  // see RULE9
         cfg.pin_sel    <= PIN_OUTPORT;
         cfg.pin_level  <= 1'b0;
         cfg.ready_mask <= 1'b0;
      end
      else
      begin
         if (aux_wr)
            cfg.mode <= dct_mode_e'(avs_writedata[AUX_MODE_LSB +: 3]);
         if (wr_en && (idx == REG_PINCFG))
         begin
            cfg.pin_sel   <= dct_pinsel_e'(avs_writedata[PIN_SEL_LSB +: 2]);
            cfg.pin_level <= avs_writedata[PIN_LVL_BIT];
         end
         if (wr_en && (idx == REG_MASK))
            cfg.ready_mask <= avs_writedata[READY_BIT];
      end
   end

   // Read data: preload offsets return the live count halves
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         avs_readdata <= '0;
      else if (rd_en)
      begin
         avs_readdata <= '0;
         case (idx)
            REG_AUX:
               avs_readdata[AUX_MODE_LSB +: 3] <= cfg.mode;
            REG_STATUS:
               avs_readdata[READY_BIT] <= ready;
            REG_MASK:
               avs_readdata[READY_BIT] <= cfg.ready_mask;
            REG_PINCFG:
            begin
               avs_readdata[PIN_SEL_LSB +: 2] <= cfg.pin_sel;
               avs_readdata[PIN_LVL_BIT]      <= cfg.pin_level;
            end
            // Live count halves share offsets with the preload bytes
            REG_PRE_HI:
               avs_readdata[BYTE_W-1:0] <= count[CNT_W-1:BYTE_W];  // see RULE16
            REG_PRE_LO:
               avs_readdata[BYTE_W-1:0] <= count[BYTE_W-1:0];      // see RULE16
            default:
               avs_readdata <= '0;
         endcase
      end
   end

   // Run state: timer mode never stops, counter waits for start
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ct_state <= CT_TIMER;  // see RULE9
      else if (aux_wr)
         ct_state <= avs_writedata[AUX_MODE_LSB + 2] ? CT_TIMER : CT_STOP;
      else
      begin
         case (ct_state)
            CT_STOP:  if (start_cmd) ct_state <= CT_COUNT;  // see RULE11
            CT_COUNT: if (stop_cmd) ct_state <= CT_STOP;    // see RULE13
            CT_TIMER: ct_state <= CT_TIMER;                 // see RULE7
            default:  ct_state <= CT_STOP;
         endcase
      end
   end

   // A half-period is preload ticks: count preload..1 then reload
   assign at_zero = (count == CNT_ONE);

   always_comb
   begin
      next_count = count;
      if (start_cmd)
         next_count = preload;  // see RULE5 see RULE15
      else if (src_tick)
      begin
         case (ct_state)
            CT_TIMER:
               next_count = at_zero ? preload : count - CNT_ONE;  // see RULE4
            CT_COUNT:
               next_count = count - CNT_ONE;  // see RULE11 see RULE13
            default:
               next_count = count;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         count <= PRELOAD_RST;
      else
         count <= next_count;
   end

   // Square wave toggles at each zero; ready on every second one
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wave     <= 1'b1;
         half_odd <= 1'b0;
      end
      else if (start_cmd)
      begin
         wave     <= 1'b1;
         half_odd <= 1'b0;
      end
      else if (src_tick && (ct_state == CT_TIMER) && at_zero)
      begin
         wave     <= ~wave;      // see RULE3 see RULE22
         half_odd <= ~half_odd;  // see RULE20
      end
   end

   // Counter output drops at terminal count, stop restores it
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ct_out <= 1'b1;
      else if (stop_cmd || start_cmd)
         ct_out <= 1'b1;  // see RULE14
      else if (src_tick && (ct_state == CT_COUNT) && at_zero)
         ct_out <= 1'b0;  // see RULE14
   end

   always_comb
   begin
      ready_set = 1'b0;
      if (src_tick && at_zero && !start_cmd)
      begin
         if (ct_state == CT_TIMER)
            ready_set = half_odd;  // see RULE6 see RULE20
         else if (ct_state == CT_COUNT)
            ready_set = 1'b1;      // see RULE12
      end
   end

   // A set in the same cycle as a stop wins, so no event is lost
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         ready <= 1'b0;
      else
         ready <= ready_set || (ready && !stop_cmd);  // see RULE7
   end

   assign interrupt_request_out = ready && cfg.ready_mask;  // see RULE21

   // Pin three is open-collector when carrying the counter/timer
   always_comb
   begin
      output_pin_three_o  = 1'b0;
      output_pin_three_oe = 1'b0;
      case (cfg.pin_sel)
         PIN_OUTPORT:
         begin
            output_pin_three_o  = ~cfg.pin_level;
            output_pin_three_oe = 1'b1;
         end
         PIN_CT:
            output_pin_three_oe = is_timer(cfg.mode)
                                  ? ~wave     // see RULE8
                                  : ~ct_out;  // see RULE14
         // Channel B clocks live outside this block: pin released
         default:
            output_pin_three_oe = 1'b0;
      endcase
   end

endmodule : dct_top

// >>> verification/dct_checker.sv
// Port-level assertions for the counter/timer top
`timescale 1ns/1ps
module dct_checker
   import dct_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   input  wire logic [DATA_W-1:0] avs_readdata,
   input  wire logic              avs_waitrequest,
   input  wire logic              output_pin_three_o,
   input  wire logic              output_pin_three_oe,
   input  wire logic              interrupt_request_out
);
   logic [2:0] mode_q;
   logic [1:0] sel_q;
   logic       lvl_q;
   logic       mask_q;
   logic [3:0] idx;
   logic       pin;
   logic       wr_go;
   assign idx   = avs_address[ADDR_W-1:2];
   // Open collector: a released pin floats high
   assign pin   = output_pin_three_oe ? output_pin_three_o : 1'b1;
   // Shadow copies follow the edge the slave takes the write on
   assign wr_go = avs_write && avs_waitrequest && avs_byteenable[0];
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         mode_q <= MODE_RST;
         sel_q  <= 2'h0;
         lvl_q  <= 1'b0;
         mask_q <= 1'b0;
      end
      else if (wr_go)
      begin
         if (idx == REG_AUX)
            mode_q <= avs_writedata[AUX_MODE_LSB +: 3];
         if (idx == REG_PINCFG)
            sel_q <= avs_writedata[PIN_SEL_LSB +: 2];
         if (idx == REG_PINCFG)
            lvl_q <= avs_writedata[PIN_LVL_BIT];
         if (idx == REG_MASK)
            mask_q <= avs_writedata[READY_BIT];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_take(logic [3:0] i);
      avs_read && avs_waitrequest && idx == i;
   endsequence
   a_wait_first: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("request answered in its first cycle");
   a_wait_one: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   a_data_byte: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data above the low byte");
   a_cmd_zero: assert property (
      (s_take(CMD_START) or s_take(CMD_STOP)) |=> avs_readdata == 32'h0)
      else $error("command read returned data");
   a_pin_reset: assert property (
      $fell(rst) |-> pin && output_pin_three_oe && !interrupt_request_out)
      else $error("pin or irq wrong after reset");
   a_pin_port: assert property (
      sel_q == PIN_OUTPORT |-> output_pin_three_oe
      && output_pin_three_o == !lvl_q)
      else $error("output port level wrong");
   a_irq_mask: assert property (
      !mask_q |-> !interrupt_request_out)
      else $error("irq raised while masked");
   a_stop_high: assert property (
      s_take(CMD_STOP) ##0 (!mode_q[2] && sel_q == PIN_CT) |=> pin)
      else $error("counter pin low after stop");
   a_start_high: assert property (
      s_take(CMD_START) ##0 (mode_q[2] && sel_q == PIN_CT) |=> pin)
      else $error("timer wave not high after start");
endmodule : dct_checker

bind dct_top dct_checker u_chk (.clk_sys, .rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .output_pin_three_o, .output_pin_three_oe,
   .interrupt_request_out);

// >>> verification/dct_host_model.sv
// Host bus master model speaking Avalon-MM to the counter/timer
`timescale 1ns/1ps
module dct_host_model
   import dct_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              go,
   input  wire logic              go_wr,
   input  wire logic [3:0]        go_idx,
   input  wire logic [7:0]        go_data,
   output logic                   done,
   output logic [7:0]             rdata,
   output logic [ADDR_W-1:0]      avs_address,
   output logic                   avs_read,
   output logic                   avs_write,
   output logic [DATA_W-1:0]      avs_writedata,
   output logic [3:0]             avs_byteenable,
   input  wire logic [DATA_W-1:0] avs_readdata,
   input  wire logic              avs_waitrequest
);
   // Registers are a byte wide, so only lane zero is ever enabled
   assign avs_byteenable = 4'h1;
   always_ff @(posedge clk_sys)
   begin
      done <= 1'b0;
      if (rst)
      begin
         avs_address   <= '0;
         avs_writedata <= '0;
         avs_read      <= 1'b0;
         avs_write     <= 1'b0;
      end
      else if (avs_read || avs_write)
      begin
         // Everything holds until the wait is lifted
         if (!avs_waitrequest)
         begin
            rdata     <= avs_readdata[7:0];
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            done      <= 1'b1;
         end
      end
      else if (go && !done)
      begin
         avs_address   <= {go_idx, 2'b00};
         avs_writedata <= {24'h000000, go_data};
         avs_read      <= !go_wr;
         avs_write     <= go_wr;
      end
   end
endmodule : dct_host_model

// >>> verification/tb_top.sv
// Self-checking bench for the counter/timer block
`timescale 1ns/1ps
module tb_top;
   import dct_pkg::*;
   logic              clk_sys;
   logic              rst;
   logic              go;
   logic              go_wr;
   logic              done;
   logic              run_ip2;
   logic [3:0]        go_idx;
   logic [7:0]        go_data;
   logic [7:0]        rdata;
   logic [2:0]        src_q;
   logic [7:0]        ph = 8'h00;
   int                mismatches;
   int                samples_checked;
   int                cyc = 0;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [DATA_W-1:0] avs_readdata;
   logic [3:0]        avs_byteenable;
   logic              avs_waitrequest;
   logic              pin_o;
   logic              pin_oe;
   logic              irq;
   wire               pin = pin_oe ? pin_o : 1'b1;

   dct_top uut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .external_input_two(run_ip2 ? ph[2] : src_q[0]),
      .chan_a_tx_1x_clock(src_q[1]), .chan_b_tx_1x_clock(src_q[2]),
      .crystal_clock_input(ph[2]), .output_pin_three_o(pin_o),
      .output_pin_three_oe(pin_oe), .interrupt_request_out(irq));
   dct_host_model u_host (.clk_sys, .rst, .go, .go_wr, .go_idx, .go_data,
      .done, .rdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest);

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      ph  <= ph + 8'h01;
      cyc <= cyc + 1;
   end

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [3:0] i,
                      input logic [7:0] d);
      int n;
      go_wr   <= w;
      go_idx  <= i;
      go_data <= d;
      go      <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (done !== 1'b1 && n < 50);
      go <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50)
         mismatches++;
   endtask : bus

   task automatic wpin(input logic v);
      int n;
      n = 0;
      // Always look at a falling edge, never in the launching time step
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (pin !== v && n < 3000);
      if (pin !== v)
         mismatches++;
   endtask : wpin

   task automatic meas(input int h);
      int t;
      wpin(1'b0);
      wpin(1'b1);
      t = cyc;
      wpin(1'b0);
      chk(16'(cyc - t), 16'(h));
      t = cyc;
      wpin(1'b1);
      chk(16'(cyc - t), 16'(h));
   endtask : meas

   task automatic pulses(input int b, input int n);
      repeat (n)
      begin
         src_q[b] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         src_q[b] <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask : pulses

   task automatic t_reset();
      chk(16'(pin & pin_oe & ~irq), 16'h0001);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'(rdata[READY_BIT]), 16'h0000);
      bus(1'b0, 4'hA, 8'hFF);
      chk(16'(rdata), 16'h0000);
      bus(1'b1, REG_PINCFG, 8'h80);
      chk(16'(pin), 16'h0000);
      bus(1'b0, REG_PINCFG, 8'h00);
      chk(16'(rdata), 16'h0080);
      $display("test reset done");
   endtask : t_reset

   task automatic t_timer();
      int t0;
      bus(1'b1, REG_PINCFG, 8'h04);
      bus(1'b1, REG_PRE_HI, 8'h00);
      bus(1'b1, REG_PRE_LO, 8'h03);
      run_ip2 <= 1'b1;
      for (int c = 4; c < 8; c++)
      begin
         bus(1'b1, REG_AUX, 8'(c << 4));
         meas(3 * 8 * (c[0] ? PRESCALE : 1));
      end
      run_ip2 <= 1'b0;
      bus(1'b1, REG_AUX, 8'h60);
      bus(1'b1, REG_PRE_LO, 8'h04);
      meas(32);
      // New preload lands inside a high half that already runs on 4
      t0 = cyc;
      bus(1'b1, REG_PRE_LO, 8'h06);
      wpin(1'b0);
      chk(16'(cyc - t0), 16'(32));
      t0 = cyc;
      wpin(1'b1);
      chk(16'(cyc - t0), 16'(48));
      meas(48);
      wpin(1'b0);
      bus(1'b0, CMD_START, 8'h00);
      @(negedge clk_sys);
      chk(16'(pin), 16'h0001);
      $display("test timer done");
   endtask : t_timer

   task automatic t_ready();
      bus(1'b1, REG_MASK, 8'h08);
      wpin(1'b0);
      wpin(1'b1);
      bus(1'b0, CMD_STOP, 8'h00);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'({rdata[READY_BIT], irq}), 16'h0000);
      wpin(1'b0);
      wpin(1'b1);
      repeat (2) @(negedge clk_sys);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'({rdata[READY_BIT], irq}), 16'h0003);
      bus(1'b0, CMD_STOP, 8'h00);
      wpin(1'b0);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'(rdata[READY_BIT]), 16'h0000);
      bus(1'b1, REG_MASK, 8'h00);
      $display("test ready done");
   endtask : t_ready

   task automatic t_counter();
      for (int c = 0; c < 3; c++)
      begin
         bus(1'b1, REG_AUX, 8'(c << 4));
         bus(1'b1, REG_PRE_LO, 8'h03);
         bus(1'b0, CMD_START, 8'h00);
         bus(1'b1, REG_PRE_LO, 8'h05);
         bus(1'b0, REG_PRE_LO, 8'h00);
         chk(16'(rdata), 16'h0003);
         pulses(c, 2);
         bus(1'b0, REG_STATUS, 8'h00);
         chk(16'({rdata[READY_BIT], pin}), 16'h0001);
         pulses(c, 2);
         bus(1'b0, REG_STATUS, 8'h00);
         chk(16'({rdata[READY_BIT], pin}), 16'h0002);
         bus(1'b0, CMD_STOP, 8'h00);
         bus(1'b0, REG_PRE_HI, 8'h00);
         chk(16'(rdata), 16'h00FF);
         bus(1'b0, REG_PRE_LO, 8'h00);
         chk(16'(rdata), 16'h00FF);
         bus(1'b0, REG_STATUS, 8'h00);
         chk(16'({rdata[READY_BIT], pin}), 16'h0001);
         bus(1'b0, CMD_START, 8'h00);
         bus(1'b0, REG_PRE_LO, 8'h00);
         chk(16'(rdata), 16'h0005);
      end
      bus(1'b1, REG_AUX, 8'h30);
      bus(1'b1, REG_PRE_LO, 8'h03);
      bus(1'b0, CMD_START, 8'h00);
      repeat (200) @(posedge clk_sys);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'(rdata[READY_BIT]), 16'h0000);
      repeat (250) @(posedge clk_sys);
      bus(1'b0, REG_STATUS, 8'h00);
      chk(16'(rdata[READY_BIT]), 16'h0001);
      bus(1'b0, REG_AUX, 8'h00);
      chk(16'(rdata), 16'h0030);
      $display("test counter done");
   endtask : t_counter

   initial
   begin
      rst             = 1'b1;
      go              = 1'b0;
      go_wr           = 1'b0;
      go_idx          = 4'h0;
      go_data         = 8'h00;
      src_q           = 3'h0;
      run_ip2         = 1'b0;
      mismatches      = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_timer();
      t_ready();
      t_counter();
      end_of_test();
   end

   // Whole run needs well under a tenth of this span
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      mismatches++;
      end_of_test();
   end
endmodule : tb_top
